// [hw/tmr3g_core.sv]
// gated 16-bit timer: gate path, single pulse, events, apb registers
// assumes gate pin and ext clock pin are asynchronous; compare unit
// and timer0/timer2 pulses are on CLOCK
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tmr3g_regs.svh"

// Overview of operation
// - single pulse waits for the go bit set after enabling the mode
// - with go set, counting enables on the next incrementing gate edge
// - go bit clears itself at the trailing edge of the pulse
// - after completion no gate event counts until go is set again
// - clearing single pulse mode also clears the go bit
// - toggle and single pulse together measure one full gate cycle
// - current gate level is readable as a status bit
// - gate level status tracks the gate with gate count disabled
// - falling edge of gate level sets the gate event flag
// - gate event request only while its enable and flag are set
// - gate event flag works with gate count disabled
// - counter runs upward 0000h to FFFFh then wraps to 0000h
// - each wrap latches overflow flag; request only when enabled
// - assigned compare unit in mode 1011 resets the count to zero
// - trigger reset may be ignored in asynchronous counter mode
// - software write to the count beats a coincident trigger reset
// - trigger reset never sets the overflow flag
// - go reads 1 while armed or running, 0 when done or unstarted
// - toggle flip-flop is held clear while toggle mode is off
// - polarity 1 counts on gate high, polarity 0 on gate low
module tmr3g_core #(
	parameter int COUNT_W = 16
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// gate sources and external count clock
	input wire logic GATE_PIN,
	input wire logic EXT_CLK_PIN,
	input wire logic T0_OVF_PULSE,
	input wire logic T2_MATCH_PULSE,
	// capture/compare units
	input wire tmr3g_pkg::tmr3g_cmode_t CMP1_MODE,
	input wire logic CMP1_TRIG,
	input wire tmr3g_pkg::tmr3g_cmode_t CMP2_MODE,
	input wire logic CMP2_TRIG,
	// interrupt requests and count
	output logic OVF_IRQ,
	output logic GATE_IRQ,
	output logic [COUNT_W-1:0] COUNT
);
	import tmr3g_pkg::*;

	// the byte registers and wrap value only make sense at 16 bits
	if (COUNT_W != 16) begin : g_chk
		$error("tmr3g_core serves COUNT_W of 16 only");
	end

	logic [COUNT_W-1:0] count_reg;
	logic [7:0] tctl_reg;
	logic tctl_on;
	logic tctl_nosync;
	tmr3g_src_t tctl_src;
	logic gen_reg;
	logic pol_reg;
	logic tgl_reg;
	logic spm_reg;
	tmr3g_gsel_t gsel_reg;
	logic [1:0] casgn_reg;
	logic ovf_flag_reg;
	logic gate_flag_reg;
	logic ovf_ien_reg;
	logic gate_ien_reg;
	tmr3g_sp_t sp_reg;
	tmr3g_sp_t sp_next;
	logic gate_pin_s1;
	logic gate_pin_s2;
	logic ext_s1;
	logic ext_s2;
	logic ext_d;
	logic gsrc;
	logic gpol;
	logic gpol_d;
	logic tff_reg;
	logic tgl_sig;
	logic tgl_d;
	logic gate_val;
	logic level_reg;
	logic tick;
	logic inc;
	logic wrap;
	logic set_hit;
	logic ready_reg;
	logic acc;
	logic wr;
	logic hit;
	logic [7:0] wb;
	logic [31:0] rd_mux;

	// a byte-wide register row read back in the low bits
	function automatic logic [31:0] zext8(input logic [7:0] v);
		return {24'h0000_00, v};
	endfunction

	// trigger counts only from a unit assigned here in the right mode
	function automatic logic set_ok(input tmr3g_cmode_t m,
		input logic trig, input logic assigned);
		return trig & assigned & (m == `TMR3G_CMP_SET);
	endfunction

	assign tctl_on = tctl_reg[`TMR3G_TC_ON];
	assign tctl_nosync = tctl_reg[`TMR3G_TC_NOSYNC];
	assign tctl_src = tmr3g_src_t'(tctl_reg[`TMR3G_TC_SRC_LO +: 2]);
	assign wb = PWDATA[7:0];

	// bus handshake: one wait cycle, so every answer comes from a flop
	assign acc = PSEL & PENABLE & ready_reg;
	assign wr = acc & PWRITE;

	// two flops on every pin before any logic looks at it
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			gate_pin_s1 <= 1'b0;
			gate_pin_s2 <= 1'b0;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_d <= 1'b0;
		end else begin
			gate_pin_s1 <= GATE_PIN;
			gate_pin_s2 <= gate_pin_s1;
			ext_s1 <= EXT_CLK_PIN;
			ext_s2 <= ext_s1;
			ext_d <= ext_s2;
		end
	end

	// gate source select, then polarity so high always means count
	always_comb begin
		case (gsel_reg)
			2'd0: gsrc = gate_pin_s2;
			2'd1: gsrc = T0_OVF_PULSE;
			2'd2: gsrc = T2_MATCH_PULSE;
			default: gsrc = 1'b0;
		endcase
		gpol = pol_reg ? gsrc : ~gsrc;
	end

	// toggle flop flips on each incrementing edge of the gate
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			gpol_d <= 1'b0;
			tff_reg <= 1'b0;
		end else begin
			gpol_d <= gpol;
			if (!tgl_reg)
				tff_reg <= 1'b0;
			else if (gpol & ~gpol_d)
				tff_reg <= ~tff_reg;
		end
	end

	// toggled signal feeds the pulse logic when both modes are on
	assign tgl_sig = tgl_reg ? tff_reg : gpol;

	// single pulse: armed by go, run from rise, done at trailing edge
	always_comb begin
		sp_next = sp_reg;
		case (sp_reg)
			SP_IDLE: sp_next = SP_IDLE;
			SP_ARMED: begin
				if (tgl_sig & ~tgl_d)
					sp_next = SP_RUN;
			end
			SP_RUN: begin
				if (~tgl_sig & tgl_d)
					sp_next = SP_IDLE;
			end
			default: sp_next = SP_IDLE;
		endcase
		if (wr && PADDR == `TMR3G_OFS_GCTL) begin
			if (!wb[`TMR3G_GC_SPM])
				sp_next = SP_IDLE;
			else if (wb[`TMR3G_GC_GO] && sp_reg == SP_IDLE && spm_reg)
				sp_next = SP_ARMED;
		end
		if (!spm_reg && sp_next != SP_IDLE)
			sp_next = SP_IDLE;
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			sp_reg <= SP_IDLE;
			tgl_d <= 1'b0;
		end else begin
			sp_reg <= sp_next;
			tgl_d <= tgl_sig;
		end
	end

	// pulse mode passes the gate only during the captured pulse
	assign gate_val = spm_reg ? (sp_reg == SP_RUN) & tgl_sig : tgl_sig;

	// level status runs regardless of gate count enable
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			level_reg <= 1'b0;
		else
			level_reg <= gate_val;
	end

	// count tick: system clock each cycle, external on a synced rise
	assign tick = (tctl_src == CS_EXT) ? (ext_s2 & ~ext_d) : 1'b1;
	assign inc = tctl_on & tick & (~gen_reg | level_reg);
	assign wrap = inc & (count_reg == {COUNT_W{1'b1}});
	// async counting cannot honour the reset, so it is dropped there
	assign set_hit = ~(tctl_src == CS_EXT & tctl_nosync) &
		(set_ok(CMP1_MODE, CMP1_TRIG, casgn_reg == 2'b10) |
		set_ok(CMP2_MODE, CMP2_TRIG, casgn_reg != 2'b00));

	// counter: software write first, then trigger reset, then count
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			count_reg <= `TMR3G_RST_CNT;
		else if (wr && PADDR == `TMR3G_OFS_CNT_LO)
			count_reg[7:0] <= wb;
		else if (wr && PADDR == `TMR3G_OFS_CNT_HI)
			count_reg[15:8] <= wb;
		else if (set_hit)
			count_reg <= `TMR3G_RST_CNT;
		else if (inc)
			count_reg <= count_reg + 16'h0001;
	end

	// control registers written by software
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			tctl_reg <= `TMR3G_RST_TCTL;
			gen_reg <= 1'(`TMR3G_RST_GCTL >> `TMR3G_GC_GEN);
			pol_reg <= 1'b0;
			tgl_reg <= 1'b0;
			spm_reg <= 1'b0;
			gsel_reg <= 2'b00;
			casgn_reg <= `TMR3G_RST_CASGN;
			ovf_ien_reg <= 1'b0;
			gate_ien_reg <= 1'b0;
		end else if (wr) begin
			case (PADDR)
				`TMR3G_OFS_TCTL: tctl_reg <= wb & 8'hF7;
				`TMR3G_OFS_GCTL: begin
					gen_reg <= wb[`TMR3G_GC_GEN];
					pol_reg <= wb[`TMR3G_GC_POL];
					tgl_reg <= wb[`TMR3G_GC_TGL];
					spm_reg <= wb[`TMR3G_GC_SPM];
					gsel_reg <= wb[`TMR3G_GC_SEL_LO +: 2];
				end
				`TMR3G_OFS_CASGN: casgn_reg <= wb[1:0];
				`TMR3G_OFS_IEN: begin
					ovf_ien_reg <= wb[`TMR3G_FL_OVF];
					gate_ien_reg <= wb[`TMR3G_FL_GATE];
				end
				default: ;
			endcase
		end
	end

	// sticky flags: writing zero clears, a new event wins the cycle
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ovf_flag_reg <= 1'b0;
			gate_flag_reg <= 1'b0;
		end else begin
			if (wrap && !set_hit && !(wr && PADDR[11:3] == 9'h000))
				ovf_flag_reg <= 1'b1;
			else if (wr && PADDR == `TMR3G_OFS_FLAGS &&
				!wb[`TMR3G_FL_OVF])
				ovf_flag_reg <= 1'b0;
			if (~gate_val & level_reg)
				gate_flag_reg <= 1'b1;
			else if (wr && PADDR == `TMR3G_OFS_FLAGS &&
				!wb[`TMR3G_FL_GATE])
				gate_flag_reg <= 1'b0;
		end
	end

	// requests follow flag and enable, one cycle later
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			OVF_IRQ <= 1'b0;
			GATE_IRQ <= 1'b0;
			COUNT <= `TMR3G_RST_CNT;
		end else begin
			OVF_IRQ <= ovf_flag_reg & ovf_ien_reg;
			GATE_IRQ <= gate_flag_reg & gate_ien_reg;
			COUNT <= count_reg;
		end
	end

	// read mux; go shows armed or running, level shows gate now
	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (PADDR)
			`TMR3G_OFS_CNT_LO: rd_mux = zext8(count_reg[7:0]);
			`TMR3G_OFS_CNT_HI: rd_mux = zext8(count_reg[15:8]);
			`TMR3G_OFS_TCTL: rd_mux = zext8(tctl_reg);
			`TMR3G_OFS_GCTL: rd_mux = zext8({gen_reg, pol_reg, tgl_reg,
				spm_reg, sp_reg != SP_IDLE, level_reg, gsel_reg});
			`TMR3G_OFS_CASGN: rd_mux = zext8({6'h00, casgn_reg});
			`TMR3G_OFS_FLAGS: rd_mux = zext8({6'h00, gate_flag_reg,
				ovf_flag_reg});
			`TMR3G_OFS_IEN: rd_mux = zext8({6'h00, gate_ien_reg,
				ovf_ien_reg});
			default: hit = 1'b0;
		endcase
	end

	// apb answer: ready in the second access cycle, data held till then
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ready_reg <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			ready_reg <= PSEL & PENABLE & ~ready_reg;
			if (PSEL & PENABLE & ~ready_reg) begin
				PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
				PSLVERR <= ~hit;
			end else begin
				PRDATA <= 32'h0000_0000;
				PSLVERR <= 1'b0;
			end
		end
	end
	assign PREADY = ready_reg;

endmodule
`default_nettype wire

// [shared/tmr3g_pkg.sv]
// types shared by the gated timer design and its bench
// assumes tmr3g_regs.svh for all numeric constants
package tmr3g_pkg;
	// single-pulse acquisition progress
	typedef enum logic [1:0] {
		SP_IDLE,
		SP_ARMED,
		SP_RUN
	} tmr3g_sp_t;
	// count clock source select
	typedef enum logic [1:0] {
		CS_SYS,
		CS_SYS4,
		CS_EXT,
		CS_RSVD
	} tmr3g_src_t;
	typedef logic [1:0] tmr3g_gsel_t;
	typedef logic [3:0] tmr3g_cmode_t;
endpackage

// [shared/tmr3g_regs.svh]
// register offsets, field positions and reset values of the gated timer
// assumes a 32-bit apb slave with one aligned word per register
`ifndef TMR3G_REGS_SVH
`define TMR3G_REGS_SVH
`define TMR3G_OFS_CNT_LO 12'h000
`define TMR3G_OFS_CNT_HI 12'h004
`define TMR3G_OFS_TCTL 12'h008
`define TMR3G_OFS_GCTL 12'h00C
`define TMR3G_OFS_CASGN 12'h010
`define TMR3G_OFS_FLAGS 12'h014
`define TMR3G_OFS_IEN 12'h018
// timer_control fields
`define TMR3G_TC_ON 0
`define TMR3G_TC_NOSYNC 2
`define TMR3G_TC_SRC_LO 6
// gate_control fields
`define TMR3G_GC_SEL_LO 0
`define TMR3G_GC_LEVEL 2
`define TMR3G_GC_GO 3
`define TMR3G_GC_SPM 4
`define TMR3G_GC_TGL 5
`define TMR3G_GC_POL 6
`define TMR3G_GC_GEN 7
// flag and enable fields
`define TMR3G_FL_OVF 0
`define TMR3G_FL_GATE 1
// reset values
`define TMR3G_RST_TCTL 8'h00
`define TMR3G_RST_GCTL 8'h00
`define TMR3G_RST_CASGN 2'h0
`define TMR3G_RST_CNT 16'h0000
// compare mode code that resets the count
`define TMR3G_CMP_SET 4'hB
`endif

// [sim/tmr3g_assertions.sv]
// checker on the timer ports: apb timing, count steps, request holds
// assumes binding into tmr3g_core; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module tmr3g_assertions #(
	parameter int COUNT_W = 16
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// requests and count
	input wire logic OVF_IRQ,
	input wire logic GATE_IRQ,
	input wire logic [COUNT_W-1:0] COUNT
);
	logic wr;
	logic wr_cnt;
	logic wr_irq;
	// writes excuse count jumps and request drops for a few cycles
	assign wr = PSEL && PENABLE && PREADY && PWRITE;
	assign wr_cnt = wr && PADDR < 12'h008;
	assign wr_irq = wr && PADDR > 12'h010;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_ready_latency: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready late");
	a_idle_data: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
		else $error("read data outside answer");
	a_err_ready: assert property (PSLVERR |-> PREADY && PENABLE)
		else $error("error without answer");
	a_count_step: assert property ($changed(COUNT) && !$past(wr_cnt, 2)
		&& !$past(wr_cnt, 3) |-> COUNT == $past(COUNT) + 1'b1 || COUNT == '0)
		else $error("count jumped");
	a_gate_hold: assert property (GATE_IRQ && !$past(wr_irq) |=> GATE_IRQ)
		else $error("gate request dropped");
	a_ovf_hold: assert property (OVF_IRQ ##1 !$past(wr_irq, 2) |-> OVF_IRQ)
		else $error("overflow request dropped");
	a_ovf_cause: assert property ($rose(OVF_IRQ) && !$past(wr_irq, 2)
		|-> COUNT < 4)
		else $error("overflow request without wrap");
	c_wrap: cover property ($rose(OVF_IRQ));
	c_gate: cover property ($rose(GATE_IRQ));
	c_err: cover property (PSLVERR);
endmodule
bind tmr3g_core tmr3g_assertions #(.COUNT_W(COUNT_W)) u_chk (.CLOCK, .RSTN,
	.PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .OVF_IRQ,
	.GATE_IRQ, .COUNT);
`default_nettype wire

// [sim/tmr3g_core_test.sv]
// bench for the gated timer: apb master, scenarios, verdict
// assumes the checker binds itself and the partner drives the gate
`timescale 1ns/10ps
`default_nettype none
`include "tmr3g_regs.svh"
module tmr3g_core_test;
	import tmr3g_pkg::*;
	logic CLOCK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic GATE_PIN, T0_OVF_PULSE, T2_MATCH_PULSE, CMP1_TRIG, CMP2_TRIG;
	logic OVF_IRQ, GATE_IRQ;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [15:0] COUNT;
	tmr3g_cmode_t CMP1_MODE, CMP2_MODE;
	int bad_count = 0;
	int comparisons = 0;
	tmr3g_core #(.COUNT_W(16)) DUT (.CLOCK, .RSTN, .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .GATE_PIN,
		.EXT_CLK_PIN(1'b0), .T0_OVF_PULSE, .T2_MATCH_PULSE, .CMP1_MODE,
		.CMP1_TRIG, .CMP2_MODE, .CMP2_TRIG, .OVF_IRQ, .GATE_IRQ, .COUNT);
	tmr3g_partner u_far (.CLOCK, .GATE_PIN, .T0_OVF_PULSE, .T2_MATCH_PULSE,
		.CMP1_MODE, .CMP1_TRIG, .CMP2_MODE, .CMP2_TRIG);
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer; the wait for ready is bounded
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			wrap_up();
		end
	endtask
	task automatic t_regs();
		apb(0, `TMR3G_OFS_GCTL, 0);
		// polarity 0 with the pin low is an active gate: level reads 1
		chk(rd, `TMR3G_RST_GCTL | 32'h0000_0004);
		apb(0, 12'h040, 0);
		chk(rd, 0);
		chk(err, 1);
		$display("registers done");
	endtask
	task automatic t_level();
		// polarity 1 first; the switch drops the level, so a flag appears
		apb(1, `TMR3G_OFS_GCTL, 8'h40);
		apb(0, `TMR3G_OFS_FLAGS, 0);
		chk(rd[1], 1);
		apb(1, `TMR3G_OFS_FLAGS, 0);
		apb(1, `TMR3G_OFS_IEN, 2);
		u_far.gate(1, 6);
		apb(0, `TMR3G_OFS_GCTL, 0);
		chk(rd[2], 1);
		chk(GATE_IRQ, 0);
		u_far.gate(0, 6);
		apb(0, `TMR3G_OFS_FLAGS, 0);
		chk(rd[1], 1);
		chk(GATE_IRQ, 1);
		apb(1, `TMR3G_OFS_IEN, 0);
		repeat (3) @(posedge CLOCK);
		chk(GATE_IRQ, 0);
		apb(1, `TMR3G_OFS_FLAGS, 0);
		apb(0, `TMR3G_OFS_FLAGS, 0);
		chk(rd[1], 0);
		$display("gate level done");
	endtask
	// a pre-go pulse is skipped in toggle mode: it would flip the toggle
	task automatic t_single(input logic tg);
		logic [15:0] c;
		apb(1, `TMR3G_OFS_TCTL, 1);
		apb(1, `TMR3G_OFS_GCTL, {2'h3, tg, 5'h10});
		apb(1, `TMR3G_OFS_CNT_LO, 0);
		apb(1, `TMR3G_OFS_CNT_HI, 0);
		if (!tg) begin
			u_far.gate(1, 6);
			u_far.gate(0, 6);
		end
		apb(1, `TMR3G_OFS_GCTL, {2'h3, tg, 5'h18});
		apb(0, `TMR3G_OFS_GCTL, 0);
		chk({rd[3], COUNT}, 17'h1_0000);
		u_far.gate(1, 6);
		u_far.gate(0, 6);
		if (tg) begin
			u_far.gate(1, 6);
			u_far.gate(0, 6);
		end
		apb(0, `TMR3G_OFS_GCTL, 0);
		chk(rd[3], 0);
		c = COUNT;
		chk(tg ? c > 16'h9 && c < 16'hF : c > 16'h3 && c < 16'h9, 1);
		u_far.gate(1, 6);
		u_far.gate(0, 6);
		chk(COUNT, c);
		apb(1, `TMR3G_OFS_GCTL, {2'h3, tg, 5'h18});
		apb(1, `TMR3G_OFS_GCTL, {2'h3, tg, 5'h08});
		apb(0, `TMR3G_OFS_GCTL, 0);
		chk(rd[3], 0);
		$display("single pulse done");
	endtask
	task automatic t_wrap();
		apb(1, `TMR3G_OFS_GCTL, 0);
		apb(1, `TMR3G_OFS_IEN, 1);
		apb(1, `TMR3G_OFS_FLAGS, 0);
		apb(1, `TMR3G_OFS_CNT_LO, 8'hF0);
		apb(1, `TMR3G_OFS_CNT_HI, 8'hFF);
		chk(OVF_IRQ, 0);
		repeat (30) @(posedge CLOCK);
		chk(OVF_IRQ, 1);
		chk(COUNT < 16'h0020, 1);
		apb(1, `TMR3G_OFS_FLAGS, 0);
		repeat (3) @(posedge CLOCK);
		chk(OVF_IRQ, 0);
		$display("wrap done");
	endtask
	task automatic t_trig();
		logic [15:0] c;
		apb(1, `TMR3G_OFS_CNT_HI, 8'h80);
		u_far.trig();
		repeat (3) @(posedge CLOCK);
		chk(COUNT[15], 1);
		// unit one is not ours while only unit two is assigned
		apb(1, `TMR3G_OFS_CASGN, 1);
		u_far.trig();
		repeat (3) @(posedge CLOCK);
		chk(COUNT[15], 1);
		apb(1, `TMR3G_OFS_CASGN, 2);
		u_far.trig();
		repeat (3) @(posedge CLOCK);
		chk(COUNT < 16'h0008, 1);
		// trigger meets the wrap: count is FFFF when it lands
		apb(1, `TMR3G_OFS_CNT_HI, 8'hFF);
		apb(1, `TMR3G_OFS_CNT_LO, 8'hFE);
		u_far.trig();
		repeat (3) @(posedge CLOCK);
		chk(COUNT < 16'h0008, 1);
		apb(0, `TMR3G_OFS_FLAGS, 0);
		chk(rd[0], 0);
		// ext source without sync: no ticks, trigger dropped
		apb(1, `TMR3G_OFS_TCTL, 8'h85);
		repeat (2) @(posedge CLOCK);
		c = COUNT;
		u_far.trig();
		repeat (3) @(posedge CLOCK);
		chk(COUNT, c);
		$display("trigger done");
	endtask
	initial begin
		RSTN = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = '0;
		PWDATA = '0;
		repeat (12) @(posedge CLOCK);
		RSTN <= 1'b1;
		t_regs();
		t_level();
		t_single(0);
		t_single(1);
		t_wrap();
		t_trig();
		wrap_up();
	end
endmodule
`default_nettype wire

// [sim/tmr3g_partner.sv]
// gate source and compare unit beside the timer
// assumes the bench calls its tasks from one process
`timescale 1ns/10ps
`default_nettype none
module tmr3g_partner (
	// clock
	input wire logic CLOCK,
	// gate sources
	output logic GATE_PIN,
	output logic T0_OVF_PULSE,
	output logic T2_MATCH_PULSE,
	// compare units
	output tmr3g_pkg::tmr3g_cmode_t CMP1_MODE,
	output logic CMP1_TRIG,
	output tmr3g_pkg::tmr3g_cmode_t CMP2_MODE,
	output logic CMP2_TRIG
);
	import tmr3g_pkg::*;
	// unit one sits in special event mode; the timer decides its use
	initial begin
		GATE_PIN = 1'b0;
		T0_OVF_PULSE = 1'b0;
		T2_MATCH_PULSE = 1'b0;
		CMP1_MODE = 4'hB;
		CMP1_TRIG = 1'b0;
		CMP2_MODE = 4'h0;
		CMP2_TRIG = 1'b0;
	end
	// one-cycle trigger, launched just after an edge
	task automatic trig();
		@(posedge CLOCK);
		CMP1_TRIG <= 1'b1;
		@(posedge CLOCK);
		CMP1_TRIG <= 1'b0;
	endtask
	// gate pin level held for n cycles
	task automatic gate(input logic v, input int n);
		@(posedge CLOCK);
		GATE_PIN <= v;
		repeat (n) @(posedge CLOCK);
	endtask
endmodule
`default_nettype wire
